// File: alu_pkg.sv
// constants and types for the move, arithmetic and logic datapath
// Behaviour
// - the immediate-to-memory move only reaches system registers 0x80 to 0x87 and writes there in one cycle.
// - bank-zero moves carry a byte between the accumulator and bank zero, whatever the bank, in one cycle.
// - both exchange forms swap the accumulator with memory and take 1+N cycles.
// - the table read loads the program word at the Y:Z pointer into product-high and the accumulator in 2 cycles.
// - add-with-carry sums accumulator, memory and carry, sets carry on overflow, 1 cycle to A and 1+N to memory.
// - add-immediate adds the byte to A in one cycle and updates carry, decimal carry and zero.
// - the bank-zero add writes A plus the bank-zero byte back to it, updates carry and takes 1+N cycles.
// - subtract-with-borrow forms A minus M minus inverted carry, carry 0 on borrow and 1 otherwise, updates DC and Z.
// - subtract of memory forms A minus M, carry 0 on borrow, 1 cycle to A and 1+N to memory.
// - subtract-immediate forms A minus the byte in one cycle with carry 0 on borrow.
// - multiply puts the low product byte in A and the high byte in product-high in 2 cycles, zero from A only.
// - AND, OR and XOR update only zero and take 1 cycle to A and 1+N to memory.
// - N is 0 for a system register operand and 1 for general RAM.
package alu_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 9;
  localparam int ROM_W = 16;
  localparam logic [ADDR_W-1:0] SYSREG_LO = 9'h080;
  localparam logic [ADDR_W-1:0] SYSREG_HI = 9'h087;
  localparam logic [ADDR_W-1:0] SYSREG_END = 9'h0FF;
  localparam logic [ADDR_W-1:0] BANK0_MASK = 9'h0FF;
  localparam logic [ADDR_W-1:0] PROD_HI_ADDR = 9'h082;
  localparam logic [ADDR_W-1:0] PTR_Z_ADDR = 9'h083;
  localparam logic [ADDR_W-1:0] PTR_Y_ADDR = 9'h084;
  localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
  localparam int TABLE_CYCLES = 2;
  localparam int MUL_CYCLES = 2;

  typedef enum logic [4:0]
  {
    OP_NOP      = 5'h00,
    OP_MOV_AM   = 5'h01,
    OP_MOV_MA   = 5'h02,
    OP_BANK_ZERO_MOVE_AM = 5'h03,
    OP_BANK_ZERO_MOVE_MA = 5'h04,
    OP_MOV_AI   = 5'h05,
    OP_MOV_MI   = 5'h06,
    OP_XCH      = 5'h07,
    OP_BANK_ZERO_EXCHANGE    = 5'h08,
    OP_TABLE    = 5'h09,
    OP_ADC_AM   = 5'h0A,
    OP_ADC_MA   = 5'h0B,
    OP_ADD_AM   = 5'h0C,
    OP_ADD_MA   = 5'h0D,
    OP_BANK_ZERO_ADD    = 5'h0E,
    OP_ADD_AI   = 5'h0F,
    OP_SBC_AM   = 5'h10,
    OP_SBC_MA   = 5'h11,
    OP_SUB_AM   = 5'h12,
    OP_SUB_MA   = 5'h13,
    OP_SUB_AI   = 5'h14,
    OP_MUL      = 5'h15,
    OP_AND_AM   = 5'h16,
    OP_AND_MA   = 5'h17,
    OP_AND_AI   = 5'h18,
    OP_OR_AM    = 5'h19,
    OP_OR_MA    = 5'h1A,
    OP_OR_AI    = 5'h1B,
    OP_XOR_AM   = 5'h1C,
    OP_XOR_MA   = 5'h1D,
    OP_XOR_AI   = 5'h1E
  } op_t;

  typedef enum logic [3:0]
  {
    ST_IDLE  = 4'b0001,
    ST_WAIT  = 4'b0010,
    ST_TABLE = 4'b0100,
    ST_MUL   = 4'b1000
  } state_t;
endpackage

// File: add_sub_unit.sv
// 8-bit adder/subtractor with carry and nibble carry
`timescale 1ns/1ps
`default_nettype none
module add_sub_unit #(
  parameter int W = 8
) (
  input  wire logic [W-1:0] a_in,
  input  wire logic [W-1:0] b_in,
  input  wire logic         carry_in,
  input  wire logic         sub_in,
  output logic      [W-1:0] sum_out,
  output logic              carry_out,
  output logic              half_out
);
  logic [W-1:0] b_eff;
  logic [W:0]   full;
  logic [4:0]   low;

  // subtraction as a + ~b + c, so carry out means no borrow
  assign b_eff = sub_in ? ~b_in : b_in;
  assign full = {1'b0, a_in} + {1'b0, b_eff} + {{W{1'b0}}, carry_in};
  assign low = {1'b0, a_in[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, carry_in};
  assign sum_out = full[W-1:0];
  assign carry_out = full[W];
  assign half_out = low[4];
endmodule
`default_nettype wire

// File: move_arith_datapath.sv
// move, exchange, table read, arithmetic, multiply and logic datapath
`timescale 1ns/1ps
`default_nettype none
module move_arith_datapath
  import alu_pkg::*;
(
  input  wire logic                ref_clk_in,
  input  wire logic                rstn_in,
  input  wire logic                clk_en_in,
  input  wire logic                start_in,
  input  wire alu_pkg::op_t        op_in,
  input  wire logic [alu_pkg::ADDR_W-1:0] addr_in,
  input  wire logic [alu_pkg::DATA_W-1:0] imm_in,
  input  wire logic [alu_pkg::DATA_W-1:0] mem_rdata_in,
  input  wire logic [alu_pkg::ROM_W-1:0]  rom_data_in,
  input  wire logic [alu_pkg::DATA_W-1:0] ptr_y_in,
  input  wire logic [alu_pkg::DATA_W-1:0] ptr_z_in,
  output logic                     busy_out,
  output logic                     done_out,
  output logic                     illegal_out,
  output logic [alu_pkg::ADDR_W-1:0] mem_addr_out,
  output logic                     mem_we_out,
  output logic [alu_pkg::DATA_W-1:0] mem_wdata_out,
  output logic [alu_pkg::ROM_W-1:0]  rom_addr_out,
  output logic [alu_pkg::DATA_W-1:0] acc_out,
  output logic                     carry_flag_out,
  output logic                     decimal_carry_flag_out,
  output logic                     zero_flag_out
);
  import alu_pkg::*;

  state_t              state_q;
  op_t                 op_q;
  logic [ADDR_W-1:0]   addr_q;
  logic [DATA_W-1:0]   acc_q;
  logic [DATA_W-1:0]   prod_hi_q;
  logic                c_q;
  logic                dc_q;
  logic                z_q;
  logic                done_q;
  logic                illegal_q;
  logic [ADDR_W-1:0]   mem_addr_q;
  logic                mem_we_q;
  logic [DATA_W-1:0]   mem_wdata_q;
  logic [ROM_W-1:0]    rom_addr_q;

  logic [ADDR_W-1:0]   eff_addr;
  logic                is_sys;
  logic                take;
  logic [DATA_W-1:0]   as_b;
  logic                as_cin;
  logic                as_sub;
  logic [DATA_W-1:0]   as_sum;
  logic                as_cout;
  logic                as_half;
  logic [2*DATA_W-1:0] product;

  assign take = clk_en_in && start_in && (state_q == ST_IDLE);
  // bank-zero forms ignore the bank bits of the address
  assign eff_addr = (op_in == OP_BANK_ZERO_MOVE_AM || op_in == OP_BANK_ZERO_MOVE_MA || op_in == OP_BANK_ZERO_EXCHANGE || op_in == OP_BANK_ZERO_ADD)
                    ? (addr_in & BANK0_MASK) : addr_in;
  assign is_sys = (eff_addr >= SYSREG_LO) && (eff_addr <= SYSREG_END);
  assign product = acc_q * mem_rdata_in;

  always_comb
  begin
    as_b = mem_rdata_in;
    as_cin = 1'b0;
    as_sub = 1'b0;
    case (op_in)
      OP_ADC_AM, OP_ADC_MA: as_cin = c_q;
      OP_ADD_AI: as_b = imm_in;
      OP_SBC_AM, OP_SBC_MA:
      begin
        as_sub = 1'b1;
        as_cin = c_q; // a + ~m + c equals a - m - not c
      end
      OP_SUB_AM, OP_SUB_MA:
      begin
        as_sub = 1'b1;
        as_cin = 1'b1;
      end
      OP_SUB_AI:
      begin
        as_sub = 1'b1;
        as_cin = 1'b1;
        as_b = imm_in;
      end
      default:
      begin
        as_b = mem_rdata_in;
      end
    endcase
  end

  add_sub_unit #(
    .W (DATA_W)
  ) u_add_sub (
    .a_in      (acc_q),
    .b_in      (as_b),
    .carry_in  (as_cin),
    .sub_in    (as_sub),
    .sum_out   (as_sum),
    .carry_out (as_cout),
    .half_out  (as_half)
  );

  // sequencer: exchanges and arithmetic/logic writes with a general RAM operand stretch one wait cycle; system registers and plain moves do not
  always_ff @(posedge ref_clk_in)
  begin
    if (!rstn_in)
    begin
      state_q <= ST_IDLE;
      op_q <= OP_NOP;
      addr_q <= '0;
      done_q <= 1'b0;
    end
    else if (clk_en_in)
    begin
      done_q <= 1'b0;
      case (state_q)
        ST_IDLE:
        begin
          if (take)
          begin
            op_q <= op_in;
            addr_q <= eff_addr;
            case (op_in)
              OP_TABLE: state_q <= ST_TABLE;
              OP_MUL: state_q <= ST_MUL;
              OP_XCH, OP_BANK_ZERO_EXCHANGE, OP_ADC_MA, OP_ADD_MA, OP_BANK_ZERO_ADD, OP_SBC_MA, OP_SUB_MA, OP_AND_MA, OP_OR_MA,
              OP_XOR_MA:
              begin
                if (is_sys)
                  done_q <= 1'b1; // N = 0
                else
                  state_q <= ST_WAIT; // N = 1
              end
              default: done_q <= 1'b1;
            endcase
          end
        end
        ST_WAIT, ST_TABLE, ST_MUL:
        begin
          state_q <= ST_IDLE;
          done_q <= 1'b1;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // accumulator, product-high and flags, all settled in the issue cycle except table read
  always_ff @(posedge ref_clk_in)
  begin
    if (!rstn_in)
    begin
      acc_q <= ACC_RESET;
      prod_hi_q <= '0;
      c_q <= 1'b0;
      dc_q <= 1'b0;
      z_q <= 1'b0;
    end
    else if (clk_en_in)
    begin
      if (take)
      begin
        case (op_in)
          OP_MOV_AM, OP_BANK_ZERO_MOVE_AM:
          begin
            acc_q <= mem_rdata_in;
            z_q <= (mem_rdata_in == '0);
          end
          OP_MOV_AI: acc_q <= imm_in;
          OP_XCH, OP_BANK_ZERO_EXCHANGE: acc_q <= mem_rdata_in; // flags untouched
          OP_ADC_AM, OP_ADD_AM, OP_ADD_AI, OP_SBC_AM, OP_SUB_AM, OP_SUB_AI:
          begin
            acc_q <= as_sum;
            c_q <= as_cout;
            dc_q <= as_half;
            z_q <= (as_sum == '0);
          end
          OP_ADC_MA, OP_ADD_MA, OP_BANK_ZERO_ADD, OP_SBC_MA, OP_SUB_MA:
          begin
            c_q <= as_cout;
            dc_q <= as_half;
            z_q <= (as_sum == '0);
          end
          OP_MUL:
          begin
            acc_q <= product[DATA_W-1:0];
            prod_hi_q <= product[2*DATA_W-1:DATA_W];
            z_q <= (product[DATA_W-1:0] == '0); // zero from A only
          end
          OP_AND_AM:
          begin
            acc_q <= acc_q & mem_rdata_in;
            z_q <= ((acc_q & mem_rdata_in) == '0);
          end
          OP_AND_AI:
          begin
            acc_q <= acc_q & imm_in;
            z_q <= ((acc_q & imm_in) == '0);
          end
          OP_OR_AM:
          begin
            acc_q <= acc_q | mem_rdata_in;
            z_q <= ((acc_q | mem_rdata_in) == '0);
          end
          OP_OR_AI:
          begin
            acc_q <= acc_q | imm_in;
            z_q <= ((acc_q | imm_in) == '0);
          end
          OP_XOR_AM:
          begin
            acc_q <= acc_q ^ mem_rdata_in;
            z_q <= ((acc_q ^ mem_rdata_in) == '0);
          end
          OP_XOR_AI:
          begin
            acc_q <= acc_q ^ imm_in;
            z_q <= ((acc_q ^ imm_in) == '0);
          end
          OP_AND_MA: z_q <= ((acc_q & mem_rdata_in) == '0);
          OP_OR_MA: z_q <= ((acc_q | mem_rdata_in) == '0);
          OP_XOR_MA: z_q <= ((acc_q ^ mem_rdata_in) == '0);
          default:
          begin
            acc_q <= acc_q;
          end
        endcase
      end
      else if (state_q == ST_TABLE)
      begin
        acc_q <= rom_data_in[DATA_W-1:0];
        prod_hi_q <= rom_data_in[ROM_W-1:DATA_W];
      end
    end
  end

  // memory write port, registered; at most one write pulse per instruction
  always_ff @(posedge ref_clk_in)
  begin
    if (!rstn_in)
    begin
      mem_addr_q <= '0;
      mem_we_q <= 1'b0;
      mem_wdata_q <= '0;
      rom_addr_q <= '0;
      illegal_q <= 1'b0;
    end
    else if (clk_en_in)
    begin
      mem_we_q <= 1'b0;
      illegal_q <= 1'b0;
      if (take)
      begin
        mem_addr_q <= eff_addr;
        rom_addr_q <= {ptr_y_in, ptr_z_in};
        case (op_in)
          OP_MOV_MA, OP_BANK_ZERO_MOVE_MA, OP_XCH, OP_BANK_ZERO_EXCHANGE:
          begin
            mem_we_q <= 1'b1;
            mem_wdata_q <= acc_q;
          end
          OP_MOV_MI:
          begin
            // outside the system window the write is dropped and flagged
            if (eff_addr >= SYSREG_LO && eff_addr <= SYSREG_HI)
            begin
              mem_we_q <= 1'b1;
              mem_wdata_q <= imm_in;
            end
            else
              illegal_q <= 1'b1;
          end
          OP_ADC_MA, OP_ADD_MA, OP_BANK_ZERO_ADD, OP_SBC_MA, OP_SUB_MA:
          begin
            mem_we_q <= 1'b1;
            mem_wdata_q <= as_sum;
          end
          OP_AND_MA:
          begin
            mem_we_q <= 1'b1;
            mem_wdata_q <= acc_q & mem_rdata_in;
          end
          OP_OR_MA:
          begin
            mem_we_q <= 1'b1;
            mem_wdata_q <= acc_q | mem_rdata_in;
          end
          OP_XOR_MA:
          begin
            mem_we_q <= 1'b1;
            mem_wdata_q <= acc_q ^ mem_rdata_in;
          end
          OP_MUL:
          begin
            // product-high lives at a system address; mirror it there
            mem_addr_q <= PROD_HI_ADDR;
            mem_we_q <= 1'b1;
            mem_wdata_q <= product[2*DATA_W-1:DATA_W];
          end
          default:
          begin
            mem_we_q <= 1'b0;
          end
        endcase
      end
      else if (state_q == ST_TABLE)
      begin
        // product-high sits at a system address; mirror it as multiply does
        mem_addr_q <= PROD_HI_ADDR;
        mem_we_q <= 1'b1;
        mem_wdata_q <= rom_data_in[ROM_W-1:DATA_W];
      end
    end
  end

  assign busy_out = (state_q != ST_IDLE);
  assign done_out = done_q;
  assign illegal_out = illegal_q;
  assign mem_addr_out = mem_addr_q;
  assign mem_we_out = mem_we_q;
  assign mem_wdata_out = mem_wdata_q;
  assign rom_addr_out = rom_addr_q;
  assign acc_out = acc_q;
  assign carry_flag_out = c_q;
  assign decimal_carry_flag_out = dc_q;
  assign zero_flag_out = z_q;
endmodule
`default_nettype wire

// File: move_arith_datapath_monitor.sv
// port-level assertions for the move and arithmetic datapath
`timescale 1ns/1ps
`default_nettype none
module move_arith_datapath_monitor
  import alu_pkg::*;
(
  input wire logic                        ref_clk_in,
  input wire logic                        rstn_in,
  input wire logic                        clk_en_in,
  input wire logic                        start_in,
  input wire alu_pkg::op_t                op_in,
  input wire logic [alu_pkg::ADDR_W-1:0]  addr_in,
  input wire logic [alu_pkg::DATA_W-1:0]  imm_in,
  input wire logic                        busy_out,
  input wire logic                        done_out,
  input wire logic                        illegal_out,
  input wire logic [alu_pkg::ADDR_W-1:0]  mem_addr_out,
  input wire logic                        mem_we_out,
  input wire logic [alu_pkg::DATA_W-1:0]  mem_wdata_out,
  input wire logic [alu_pkg::DATA_W-1:0]  acc_out,
  input wire logic                        carry_flag_out,
  input wire logic                        decimal_carry_flag_out,
  input wire logic                        zero_flag_out
);
  logic              issue;
  logic              slow;
  logic              in_sys;
  logic              in_imm;
  logic [ADDR_W-1:0] ea;
  assign issue = clk_en_in && start_in && !busy_out;
  assign ea = (op_in inside {OP_BANK_ZERO_EXCHANGE, OP_BANK_ZERO_ADD}) ? (addr_in & BANK0_MASK) : addr_in;
  assign in_sys = ea >= SYSREG_LO && ea <= SYSREG_END;
  assign in_imm = addr_in >= SYSREG_LO && addr_in <= SYSREG_HI;
  assign slow = (op_in inside {OP_TABLE, OP_MUL}) || (!in_sys && (op_in inside {OP_XCH, OP_BANK_ZERO_EXCHANGE, OP_ADC_MA,
                OP_ADD_MA, OP_BANK_ZERO_ADD, OP_SBC_MA, OP_SUB_MA, OP_AND_MA, OP_OR_MA, OP_XOR_MA}));
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);
  // move-immediate excluded: imm_move_a checks its completion for targets in range
  fast_done_a: assert property (issue && !slow && !(op_in inside {OP_NOP, OP_MOV_MI}) |=>
    done_out && !busy_out) else $error("one cycle op not done after one cycle");
  slow_done_a: assert property (issue && slow |=> busy_out && !done_out ##1 done_out && !busy_out)
    else $error("two cycle op timing wrong");
  imm_move_a: assert property (issue && op_in == OP_MOV_MI && in_imm |=> done_out && mem_we_out
    && mem_addr_out == $past(addr_in) && mem_wdata_out == $past(imm_in)) else $error("immediate move wrong");
  bad_move_a: assert property (issue && op_in == OP_MOV_MI && !in_imm |=> illegal_out && !mem_we_out)
    else $error("immediate move outside range not refused");
  bank_move_a: assert property (issue && op_in == OP_BANK_ZERO_MOVE_MA |=> mem_we_out
    && mem_addr_out == ($past(addr_in) & BANK0_MASK) && mem_wdata_out == $past(acc_out))
    else $error("bank zero store wrong");
  add_carry_a: assert property (issue && op_in == OP_ADD_AI |=> carry_flag_out
    == (({1'b0, $past(acc_out)} + {1'b0, $past(imm_in)}) > 9'h0FF)) else $error("add immediate carry wrong");
  sub_carry_a: assert property (issue && op_in == OP_SUB_AI |=> carry_flag_out
    == ($past(acc_out) >= $past(imm_in))) else $error("subtract immediate carry wrong");
  logic_flags_a: assert property (issue && (op_in inside {OP_AND_AI, OP_OR_AI, OP_XOR_AI}) |=>
    $stable(carry_flag_out) && $stable(decimal_carry_flag_out) && zero_flag_out == (acc_out == 8'h00))
    else $error("logic op flags wrong");
  table_c: cover property (issue && op_in == OP_TABLE);
  mul_c: cover property (issue && op_in == OP_MUL);
  bad_c: cover property (issue && op_in == OP_MOV_MI && !in_imm);
endmodule
`default_nettype wire

// File: datapath_mem_model.sv
// data memory and program word model on the far side of the datapath
`timescale 1ns/1ps
`default_nettype none
module datapath_mem_model
  import alu_pkg::*;
#(
  parameter logic [15:0] ROM_KEY = 16'hC35A
) (
  input  wire logic                        clk_in,
  input  wire logic [alu_pkg::ADDR_W-1:0]  rd_addr_in,
  input  wire logic                        we_in,
  input  wire logic [alu_pkg::ADDR_W-1:0]  wr_addr_in,
  input  wire logic [alu_pkg::DATA_W-1:0]  wdata_in,
  input  wire logic [alu_pkg::ROM_W-1:0]   rom_addr_in,
  output logic      [alu_pkg::DATA_W-1:0]  rdata_out,
  output logic      [alu_pkg::ROM_W-1:0]   rom_data_out
);
  // ram starts unknown so an operand read before any store cannot pass by luck
  logic [DATA_W-1:0] ram_q [0:511];
  always @(posedge clk_in)
    if (we_in)
      ram_q[wr_addr_in] <= wdata_in;
  assign rdata_out = ram_q[rd_addr_in];
  assign rom_data_out = rom_addr_in ^ ROM_KEY;
endmodule
`default_nettype wire

// File: testbench.sv
// self-checking bench for the move and arithmetic datapath
`timescale 1ns/1ps
`default_nettype none
bind move_arith_datapath move_arith_datapath_monitor u_mon (.ref_clk_in, .rstn_in, .clk_en_in, .start_in,
  .op_in, .addr_in, .imm_in, .busy_out, .done_out, .illegal_out, .mem_addr_out, .mem_we_out, .mem_wdata_out,
  .acc_out, .carry_flag_out, .decimal_carry_flag_out, .zero_flag_out);
module testbench;
  import alu_pkg::*;
  logic              ref_clk_in = 1'b0;
  logic              rstn_in = 1'b0;
  logic              clk_en_in = 1'b1;
  logic              start_in = 1'b0;
  op_t               op_in = OP_NOP;
  logic [ADDR_W-1:0] addr_in = 9'h000;
  logic [ADDR_W-1:0] rd_addr = 9'h000;
  logic [DATA_W-1:0] imm_in = 8'h00;
  logic [DATA_W-1:0] ptr_y_in = 8'h12;
  logic [DATA_W-1:0] ptr_z_in = 8'h34;
  logic [DATA_W-1:0] mem_rdata_in, acc_out, mem_wdata_out;
  logic [ROM_W-1:0]  rom_data_in, rom_addr_out;
  logic [ADDR_W-1:0] mem_addr_out;
  logic              busy_out, done_out, illegal_out, mem_we_out;
  logic              carry_flag_out, decimal_carry_flag_out, zero_flag_out;
  int                err_count = 0;
  int                check_count = 0;
  int                cyc;
  op_t               ops [21] = '{OP_ADC_AM, OP_ADC_MA, OP_ADD_AM, OP_ADD_MA, OP_BANK_ZERO_ADD, OP_ADD_AI, OP_SBC_AM,
    OP_SBC_MA, OP_SUB_AM, OP_SUB_MA, OP_SUB_AI, OP_MUL, OP_AND_AM, OP_AND_MA, OP_AND_AI, OP_OR_AM, OP_OR_MA,
    OP_OR_AI, OP_XOR_AM, OP_XOR_MA, OP_XOR_AI};
  always #12.5 ref_clk_in = ~ref_clk_in;
  move_arith_datapath u_dut (.ref_clk_in, .rstn_in, .clk_en_in, .start_in, .op_in, .addr_in, .imm_in,
    .mem_rdata_in, .rom_data_in, .ptr_y_in, .ptr_z_in, .busy_out, .done_out, .illegal_out, .mem_addr_out,
    .mem_we_out, .mem_wdata_out, .rom_addr_out, .acc_out, .carry_flag_out, .decimal_carry_flag_out, .zero_flag_out);
  datapath_mem_model u_mem (.clk_in(ref_clk_in), .rd_addr_in(rd_addr), .we_in(mem_we_out), .wr_addr_in(mem_addr_out),
    .wdata_in(mem_wdata_out), .rom_addr_in(rom_addr_out), .rdata_out(mem_rdata_in), .rom_data_out(rom_data_in));
  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cmp_data(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_cycles(input int got, input int exp);
    check_count++;
    if (got != exp)
    begin
      err_count++;
      $display("Error %0t took %0d cycles expected %0d", $time, got, exp);
    end
  endtask
  function automatic logic [8:0] eff(input op_t op, input logic [8:0] a);
    return (op inside {OP_BANK_ZERO_MOVE_AM, OP_BANK_ZERO_MOVE_MA, OP_BANK_ZERO_EXCHANGE, OP_BANK_ZERO_ADD}) ? (a & BANK0_MASK) : a;
  endfunction
  function automatic logic [9:0] alu_ref(input op_t op, input logic [7:0] a, input logic [7:0] m, input logic c);
    logic [8:0] s;
    logic [4:0] h;
    logic [7:0] b;
    logic       ci;
    b = (op inside {OP_SBC_AM, OP_SBC_MA, OP_SUB_AM, OP_SUB_MA, OP_SUB_AI}) ? ~m : m;
    ci = (op inside {OP_ADC_AM, OP_ADC_MA, OP_SBC_AM, OP_SBC_MA}) ? c : (op inside {OP_SUB_AM, OP_SUB_MA, OP_SUB_AI});
    s = {1'b0, a} + {1'b0, b} + 9'(ci);
    h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + 5'(ci);
    if (op inside {OP_AND_AM, OP_AND_MA, OP_AND_AI})
      return {a & m, c, c};
    if (op inside {OP_OR_AM, OP_OR_MA, OP_OR_AI})
      return {a | m, c, c};
    if (op inside {OP_XOR_AM, OP_XOR_MA, OP_XOR_AI})
      return {a ^ m, c, c};
    if (op == OP_MUL)
      return {a * m, c, c};
    return {s[7:0], s[8], h[4]};
  endfunction
  task automatic run(input op_t op, input logic [8:0] a, input logic [7:0] i, output int n);
    @(posedge ref_clk_in);
    start_in <= 1'b1;
    op_in <= op;
    addr_in <= a;
    imm_in <= i;
    rd_addr <= eff(op, a);
    @(posedge ref_clk_in);
    start_in <= 1'b0;
    n = 1;
    #1;
    while (done_out !== 1'b1 && n < 9)
    begin
      @(posedge ref_clk_in);
      #1;
      n++;
    end
  endtask
  task automatic poke(input logic [8:0] a, input logic [7:0] v);
    run(OP_MOV_AI, 9'h000, v, cyc);
    run(OP_MOV_MA, a, 8'h00, cyc);
  endtask
  // carry and decimal carry both end equal to c, so logic ops can expect them unchanged
  task automatic arith(input op_t op, input logic [8:0] a, input logic [7:0] acc0, input logic [7:0] v,
                       input logic c);
    logic [9:0] r;
    logic [8:0] ea;
    logic       tomem;
    ea = eff(op, a);
    tomem = op inside {OP_ADC_MA, OP_ADD_MA, OP_BANK_ZERO_ADD, OP_SBC_MA, OP_SUB_MA, OP_AND_MA, OP_OR_MA, OP_XOR_MA};
    r = alu_ref(op, acc0, v, c);
    poke(ea, v);
    run(OP_MOV_AI, 9'h000, 8'hFF, cyc);
    run(OP_ADD_AI, 9'h000, {7'h00, c}, cyc);
    run(OP_MOV_AI, 9'h000, acc0, cyc);
    run(op, a, v, cyc);
    cmp_cycles(cyc, (op == OP_MUL || (tomem && !(ea >= SYSREG_LO && ea <= SYSREG_END))) ? 2 : 1);
    cmp_data(16'(carry_flag_out), 16'(r[1]));
    cmp_data(16'(decimal_carry_flag_out), 16'(r[0]));
    cmp_data(16'(zero_flag_out), 16'(r[9:2] == 8'h00));
    @(posedge ref_clk_in);
    #1;
    cmp_data(16'(acc_out), 16'(tomem ? acc0 : r[9:2]));
    if (tomem)
      cmp_data(16'(u_mem.ram_q[ea]), 16'(r[9:2]));
    if (op == OP_MUL)
      cmp_data(16'(u_mem.ram_q[PROD_HI_ADDR]), (16'(acc0) * 16'(v)) >> 8);
  endtask
  task automatic t_moves();
    poke(9'h045, 8'hC3);
    poke(9'h088, 8'h11);
    run(OP_BANK_ZERO_MOVE_AM, 9'h145, 8'h00, cyc);
    cmp_data(16'(acc_out), 16'h00C3);
    run(OP_BANK_ZERO_MOVE_MA, 9'h177, 8'h00, cyc);
    cmp_cycles(cyc, 1);
    run(OP_MOV_MI, 9'h085, 8'h5A, cyc);
    @(posedge ref_clk_in);
    start_in <= 1'b1;
    op_in <= OP_MOV_MI;
    addr_in <= 9'h088;
    imm_in <= 8'h77;
    @(posedge ref_clk_in);
    start_in <= 1'b0;
    #1;
    cmp_data(16'(illegal_out), 16'h0001);
    repeat (3) @(posedge ref_clk_in);
    cmp_data({u_mem.ram_q[9'h077], u_mem.ram_q[9'h085]}, 16'hC35A);
    cmp_data(16'(u_mem.ram_q[9'h088]), 16'h0011);
  endtask
  task automatic t_exchange();
    poke(9'h030, 8'h66);
    poke(9'h0A0, 8'h44);
    run(OP_MOV_AI, 9'h000, 8'h99, cyc);
    run(OP_XCH, 9'h030, 8'h00, cyc);
    cmp_cycles(cyc, 2);
    run(OP_BANK_ZERO_EXCHANGE, 9'h1A0, 8'h00, cyc);
    cmp_cycles(cyc, 1);
    cmp_data(16'(acc_out), 16'h0044);
    @(posedge ref_clk_in);
    #1;
    cmp_data({u_mem.ram_q[9'h030], u_mem.ram_q[9'h0A0]}, 16'h9966);
  endtask
  task automatic t_table_busy();
    logic [15:0] w;
    w = {ptr_y_in, ptr_z_in} ^ u_mem.ROM_KEY;
    run(OP_TABLE, 9'h000, 8'h00, cyc);
    cmp_cycles(cyc, 2);
    cmp_data(16'(acc_out), 16'(w[7:0]));
    @(posedge ref_clk_in);
    #1;
    cmp_data(16'(u_mem.ram_q[PROD_HI_ADDR]), 16'(w[15:8]));
    poke(9'h050, 8'h03);
    run(OP_MOV_AI, 9'h000, 8'h07, cyc);
    @(posedge ref_clk_in);
    start_in <= 1'b1;
    op_in <= OP_MUL;
    addr_in <= 9'h050;
    rd_addr <= 9'h050;
    @(posedge ref_clk_in);
    op_in <= OP_ADD_AI;
    imm_in <= 8'h10;
    @(posedge ref_clk_in);
    start_in <= 1'b0;
    clk_en_in <= 1'b0;
    @(posedge ref_clk_in);
    start_in <= 1'b1;
    op_in <= OP_MOV_AI;
    @(posedge ref_clk_in);
    start_in <= 1'b0;
    clk_en_in <= 1'b1;
    repeat (2) @(posedge ref_clk_in);
    cmp_data(16'(acc_out), 16'h0015);
  endtask
  initial
  begin
    repeat (20) @(posedge ref_clk_in);
    rstn_in <= 1'b1;
    #1;
    cmp_data({acc_out, 5'h00, carry_flag_out, decimal_carry_flag_out, zero_flag_out}, {ACC_RESET, 8'h00});
    t_moves();
    t_exchange();
    t_table_busy();
    arith(OP_BANK_ZERO_ADD, 9'h140, 8'h33, 8'h44, 1'b0);
    arith(OP_ADD_AI, 9'h000, 8'h80, 8'h80, 1'b0);
    arith(OP_SUB_MA, 9'h081, 8'h20, 8'h20, 1'b0);
    foreach (ops[k])
      arith(ops[k], 9'h020 + 9'(k * 43), 8'h9C + 8'(k * 61), 8'h6E + 8'(k * 41), k[0]);
    stop_test();
  end
  initial
  begin
    #(25 * 20000);
    err_count++;
    stop_test();
  end
endmodule
`default_nettype wire
